//--- core/port_pad_pull_wiredor_control.v
// pad control for the four-pin serial port and the shared second port pins
// assumes an axi4-lite master on aclk, pads resolved from out/oe outside
// pull enables are levels; the pad cell owns the actual devices
//
// How it works
// [R01] input pin pulls only when enable set
// [R02] output pin pulls only in wired-or mode
// [R03] pull direction comes from polarity register
// [R04] polarity one pulls down, zero pulls up
// [R05] wired-or bit: one open-drain, zero push-pull
// [R06] open-drain drives low, releases for one
// [R07] wired-or ignored on input pins
// [R08] wired-or register readable and writable anytime
// [R09] reserved slot reads zero, writes ignored
// [R10] second port bits 5,4 are gpio
// [R11] gpio output drives data register bit
// [R12] read: data bit if output, else pin
// [R13] enabled spi overrides gpio on shared pins
// [R14] direction one output, zero input
// [R15] registers eight bits, upper bits zero
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "pad_ctrl_defines.vh"

module port_pad_pull_wiredor_control #(
   parameter S_PINS = 4
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // serial port pads
   input wire [S_PINS-1:0] s_pad_in,
   output wire [S_PINS-1:0] s_pad_out,
   output wire [S_PINS-1:0] s_pad_oe,
   output wire [S_PINS-1:0] s_pull_up_en,
   output wire [S_PINS-1:0] s_pull_down_en,
   // serial port alternate function (other serial peripheral)
   input wire [S_PINS-1:0] s_alt_en,
   input wire [S_PINS-1:0] s_alt_dir,
   input wire [S_PINS-1:0] s_alt_out,
   // shared spi pads of the second port (bit1 clock, bit0 master-out)
   input wire [1:0] m_pad_in,
   output wire [1:0] m_pad_out,
   output wire [1:0] m_pad_oe,
   // spi function on the shared pins
   input wire [1:0] spi_out,
   input wire [1:0] spi_oe,
   output wire [1:0] spi_in
);

   // registers
   reg [S_PINS-1:0] pull_en_r;
   reg [S_PINS-1:0] pull_pol_r;
   reg [S_PINS-1:0] open_drain_r;
   reg [S_PINS-1:0] s_dir_r;
   reg [S_PINS-1:0] s_dat_r;
   reg [1:0] m_dat_r;
   reg [1:0] m_dir_r;
   reg spi_en_r;
   // bus handshake state
   reg aw_hold_r;
   reg w_hold_r;
   reg [7:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg w_lane0_r;

   // reset values, cut to the implemented width where used
   localparam [7:0] PULL_EN_INIT = `RST_PULL_ENABLE;
   localparam [7:0] PULL_POL_INIT = `RST_PULL_POLARITY;
   localparam [7:0] OPEN_DRAIN_INIT = `RST_OPEN_DRAIN;
   localparam [7:0] DIR_INIT = `RST_DIRECTION;
   localparam [7:0] M_DATA_INIT = `RST_M_PIN_DATA;
   localparam [7:0] S_DATA_INIT = `RST_S_OUT_DATA;

   // pick the two shared-pin bits out of a register byte
   function [1:0] m_field;
      input [7:0] b;
      begin
         m_field = {b[`M_SCK_BIT], b[`M_MOSI_BIT]};
      end
   endfunction

   // true when the offset maps to a register
   function addr_ok;
      input [7:0] a;
      begin
         case (a)
            `OFS_PULL_ENABLE, `OFS_PULL_POLARITY, `OFS_OPEN_DRAIN,
            `OFS_RESERVED_SLOT, `OFS_M_PIN_DATA, `OFS_S_DIRECTION,
            `OFS_S_OUT_DATA, `OFS_M_DIRECTION, `OFS_SPI_ENABLE,
            `OFS_S_PIN_LEVEL: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
         endcase
      end
   endfunction

   // per-pin direction, value, wired-or and pulls of the serial port
   wire [S_PINS-1:0] s_is_out;
   wire [S_PINS-1:0] s_val;
   wire [S_PINS-1:0] s_od;
   wire [S_PINS-1:0] pull_act;
   genvar gi;
   generate
      for (gi = 0; gi < S_PINS; gi = gi + 1) begin : g_spin
         // alternate function owns direction and value while enabled
         assign s_is_out[gi] = s_alt_en[gi] ? s_alt_dir[gi] : s_dir_r[gi]; // R14
         assign s_val[gi] = s_alt_en[gi] ? s_alt_out[gi] : s_dat_r[gi];
         // wired-or only matters on an output
         assign s_od[gi] = s_is_out[gi] & open_drain_r[gi]; // R05 R07
         // inputs pull by enable, outputs only in wired-or
         assign pull_act[gi] = pull_en_r[gi] & (~s_is_out[gi] | s_od[gi]); // R01 R02
         // polarity bit picks the device: one down, zero up
         assign s_pull_down_en[gi] = pull_act[gi] & pull_pol_r[gi]; // R03 R04
         assign s_pull_up_en[gi] = pull_act[gi] & ~pull_pol_r[gi]; // R03 R04
         // open-drain releases the pin for a one, drives only a zero
         assign s_pad_oe[gi] = s_is_out[gi] & ~(s_od[gi] & s_val[gi]); // R06
         assign s_pad_out[gi] = s_val[gi] & ~s_od[gi]; // R06
      end
   endgenerate

   // shared second port pins: spi wins over gpio
   assign m_pad_oe = spi_en_r ? spi_oe : m_dir_r; // R13 R14
   assign m_pad_out = spi_en_r ? spi_out : m_dat_r; // R11 R13
   assign spi_in = m_pad_in;

   // write path: take address and data in either order
   wire aw_go = s_axi_awvalid & ~aw_hold_r & ~s_axi_bvalid;
   wire w_go = s_axi_wvalid & ~w_hold_r & ~s_axi_bvalid;
   assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
   wire have_aw = aw_hold_r | aw_go;
   wire have_w = w_hold_r | w_go;
   wire [7:0] wr_addr = aw_hold_r ? aw_addr_r : s_axi_awaddr;
   wire [31:0] wr_data = w_hold_r ? w_data_r : s_axi_wdata;
   wire wr_lane0 = w_hold_r ? w_lane0_r : s_axi_wstrb[0];
   wire do_wr = have_aw & have_w;
   wire wr_en = do_wr & wr_lane0;
   wire [7:0] wb = wr_data[7:0];

   // write address holding register
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (do_wr) begin
         aw_hold_r <= 1'b0;
      end else if (aw_go) begin
         aw_hold_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end
   end

   // write data holding register
   always @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_lane0_r <= 1'b0;
      end else if (do_wr) begin
         w_hold_r <= 1'b0;
      end else if (w_go) begin
         w_hold_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_lane0_r <= s_axi_wstrb[0];
      end
   end

   // write response: raised once both halves are in, held until bready
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_ok(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // one write strobe per register; reserved slot and pin level get none
   wire we_pull_en = wr_en & (wr_addr == `OFS_PULL_ENABLE);
   wire we_pull_pol = wr_en & (wr_addr == `OFS_PULL_POLARITY);
   wire we_open_drain = wr_en & (wr_addr == `OFS_OPEN_DRAIN); // R08
   wire we_m_data = wr_en & (wr_addr == `OFS_M_PIN_DATA);
   wire we_s_dir = wr_en & (wr_addr == `OFS_S_DIRECTION);
   wire we_s_data = wr_en & (wr_addr == `OFS_S_OUT_DATA);
   wire we_m_dir = wr_en & (wr_addr == `OFS_M_DIRECTION);
   wire we_spi_en = wr_en & (wr_addr == `OFS_SPI_ENABLE);

   // pull enable, written anytime
   always @(posedge aclk) begin
      if (!aresetn) begin
         pull_en_r <= PULL_EN_INIT[S_PINS-1:0];
      end else if (we_pull_en) begin
         pull_en_r <= wb[S_PINS-1:0];
      end
   end

   // pull polarity, written anytime
   always @(posedge aclk) begin
      if (!aresetn) begin
         pull_pol_r <= PULL_POL_INIT[S_PINS-1:0];
      end else if (we_pull_pol) begin
         pull_pol_r <= wb[S_PINS-1:0];
      end
   end

   // wired-or mode, written anytime
   always @(posedge aclk) begin
      if (!aresetn) begin
         open_drain_r <= OPEN_DRAIN_INIT[S_PINS-1:0];
      end else if (we_open_drain) begin
         open_drain_r <= wb[S_PINS-1:0]; // R08
      end
   end

   // second port data, shared pin bits only
   always @(posedge aclk) begin
      if (!aresetn) begin
         m_dat_r <= m_field(M_DATA_INIT);
      end else if (we_m_data) begin
         m_dat_r <= m_field(wb); // R10
      end
   end

   // serial port direction
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_dir_r <= DIR_INIT[S_PINS-1:0];
      end else if (we_s_dir) begin
         s_dir_r <= wb[S_PINS-1:0];
      end
   end

   // serial port output data
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_dat_r <= S_DATA_INIT[S_PINS-1:0];
      end else if (we_s_data) begin
         s_dat_r <= wb[S_PINS-1:0];
      end
   end

   // second port direction, shared pin bits only
   always @(posedge aclk) begin
      if (!aresetn) begin
         m_dir_r <= m_field(DIR_INIT);
      end else if (we_m_dir) begin
         m_dir_r <= m_field(wb);
      end
   end

   // spi enable
   always @(posedge aclk) begin
      if (!aresetn) begin
         spi_en_r <= 1'b0;
      end else if (we_spi_en) begin
         spi_en_r <= wb[0];
      end
   end

   // read value of the second port data register per pin
   wire [1:0] m_rd = (m_dir_r & m_dat_r) | (~m_dir_r & m_pad_in); // R12
   reg [7:0] rd_byte;
   // read mux, upper bits zero
   always @* begin
      rd_byte = 8'h00; // R15
      case (s_axi_araddr)
         `OFS_PULL_ENABLE: rd_byte[S_PINS-1:0] = pull_en_r;
         `OFS_PULL_POLARITY: rd_byte[S_PINS-1:0] = pull_pol_r;
         `OFS_OPEN_DRAIN: rd_byte[S_PINS-1:0] = open_drain_r; // R08
         `OFS_RESERVED_SLOT: rd_byte = `RST_RESERVED_VALUE; // R09
         `OFS_M_PIN_DATA: begin
            rd_byte[`M_SCK_BIT] = m_rd[1]; // R10
            rd_byte[`M_MOSI_BIT] = m_rd[0];
         end
         `OFS_S_DIRECTION: rd_byte[S_PINS-1:0] = s_dir_r;
         `OFS_S_OUT_DATA: rd_byte[S_PINS-1:0] = s_dat_r;
         `OFS_M_DIRECTION: begin
            rd_byte[`M_SCK_BIT] = m_dir_r[1];
            rd_byte[`M_MOSI_BIT] = m_dir_r[0];
         end
         `OFS_SPI_ENABLE: rd_byte[0] = spi_en_r;
         `OFS_S_PIN_LEVEL: rd_byte[S_PINS-1:0] = s_pad_in;
         default: rd_byte = 8'h00;
      endcase
   end

   // read channel: one read at a time
   assign s_axi_arready = ~s_axi_rvalid;

   // read valid: raised on an accepted address, held until rready
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // read data and response, captured with the address
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= addr_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

endmodule
`default_nettype wire

//--- inc/pad_ctrl_defines.vh
// register map, field positions and reset values of the port pad control slice
// assumes a 32-bit axi4-lite bus with word-aligned registers
`ifndef PAD_CTRL_DEFINES_VH
`define PAD_CTRL_DEFINES_VH

// byte offsets of the registers
`define OFS_PULL_ENABLE 8'h00
`define OFS_PULL_POLARITY 8'h04
`define OFS_OPEN_DRAIN 8'h08
`define OFS_RESERVED_SLOT 8'h0c
`define OFS_M_PIN_DATA 8'h10
`define OFS_S_DIRECTION 8'h14
`define OFS_S_OUT_DATA 8'h18
`define OFS_M_DIRECTION 8'h1c
`define OFS_SPI_ENABLE 8'h20
`define OFS_S_PIN_LEVEL 8'h24

// reset values
`define RST_PULL_ENABLE 8'h00
`define RST_PULL_POLARITY 8'h00
`define RST_OPEN_DRAIN 8'h00
`define RST_M_PIN_DATA 8'h00
`define RST_S_OUT_DATA 8'h00
`define RST_DIRECTION 8'h00
`define RST_RESERVED_VALUE 8'h00

// field positions in the second port data register
`define M_SCK_BIT 5
`define M_MOSI_BIT 4

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- dv/pad_props.sv
// port checker for the pad control slice
// assumes a bind onto the design top
`timescale 1ns/10ps
`default_nettype none
module pad_props (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // pins
   input wire logic [3:0] s_pull_up_en,
   input wire logic [3:0] s_pull_down_en,
   input wire logic [1:0] m_pad_in,
   input wire logic [1:0] spi_in
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // pull and pin relations
   a_pull_one_way: assert property (!(|(s_pull_up_en & s_pull_down_en)))
      else $error("both pulls on");
   a_spi_in_pin: assert property (spi_in == m_pad_in)
      else $error("spi input not pin");
   // bus answers
   a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper bits set");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> s_axi_bvalid)
      else $error("no write answer");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read answer");
   a_wr_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeats");
   a_rd_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeats");
   a_rsvd_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0c
      |=> s_axi_rdata == 32'h0)
      else $error("reserved not zero");
   // main scenarios
   c_pull_down: cover property (s_pull_down_en != 4'h0);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind port_pad_pull_wiredor_control pad_props i_props (.*);
`default_nettype wire

//--- dv/pad_board.sv
// board model: pin levels from drivers and pulls
// assumes the design pad outputs by name
`timescale 1ns/10ps
`default_nettype none
module pad_board (
   // clock
   input wire logic aclk,
   // pads
   input wire logic [3:0] s_pad_out,
   input wire logic [3:0] s_pad_oe,
   input wire logic [3:0] s_pull_up_en,
   input wire logic [3:0] s_pull_down_en,
   output logic [3:0] s_pad_in
);
   logic [3:0] flt_r = 4'h0;
   // floating pins wander every cycle
   always @(posedge aclk) flt_r <= ~flt_r;
   // driver wins, then pull, else floating
   always_comb for (int i = 0; i < 4; i++)
      s_pad_in[i] = s_pad_oe[i] ? s_pad_out[i] : s_pull_down_en[i] ? 1'b0 :
         s_pull_up_en[i] ? 1'b1 : flt_r[i];
endmodule
`default_nettype wire

//--- dv/testbench.sv
// bench for the pad control slice
// assumes design, checker and board model
`timescale 1ns/10ps
`default_nettype none
`include "pad_ctrl_defines.vh"
`define CHK(n,e,s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb, s_pad_in, s_alt_en, s_alt_dir, s_alt_out;
   logic [1:0] m_pad_in, spi_out, spi_oe;
   wire [1:0] s_axi_bresp, s_axi_rresp, m_pad_out, m_pad_oe, spi_in;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [31:0] s_axi_rdata;
   wire [3:0] s_pad_out, s_pad_oe, s_pull_up_en, s_pull_down_en;
   int bad_count = 0;
   int n_compared = 0;
   port_pad_pull_wiredor_control i_dut (.*);
   pad_board i_board (.*);
   // bus write, then check response
   task wr(input [7:0] a, input [7:0] d, input [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      `CHK("bresp", r, s_axi_bresp)
   endtask
   // bus read, then check data
   task rd(input [7:0] a, input [7:0] e, input [1:0] r);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      `CHK("rdata", {24'h0, e}, s_axi_rdata)
      `CHK("rresp", r, s_axi_rresp)
   endtask
   // pad outputs after settling
   task pads(input [3:0] oe, o, pu, pd);
      @(negedge aclk);
      `CHK("oe", oe, s_pad_oe)
      `CHK("out", o & oe, s_pad_out & oe)
      `CHK("up", pu, s_pull_up_en)
      `CHK("down", pd, s_pull_down_en)
      @(posedge aclk);
   endtask
   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // clock
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // watchdog
   initial begin
      #50000;
      bad_count++;
      complete_run;
   end
   // tests
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
      {s_alt_en, s_alt_dir, s_alt_out} = 12'h0;
      {m_pad_in, spi_out, spi_oe} = 6'h15;
      aresetn = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`OFS_PULL_ENABLE, 8'h00, 2'h0);
      rd(`OFS_M_PIN_DATA, 8'h10, 2'h0);
      wr(`OFS_RESERVED_SLOT, 8'hff, 2'h0);
      rd(`OFS_RESERVED_SLOT, 8'h00, 2'h0);
      wr(8'h30, 8'h01, 2'h2);
      rd(8'h30, 8'h00, 2'h2);
      wr(`OFS_PULL_ENABLE, 8'hff, 2'h0);
      rd(`OFS_PULL_ENABLE, 8'h0f, 2'h0);
      wr(`OFS_PULL_POLARITY, 8'h05, 2'h0);
      pads(4'h0, 4'h0, 4'ha, 4'h5);
      wr(`OFS_OPEN_DRAIN, 8'h0f, 2'h0);
      rd(`OFS_OPEN_DRAIN, 8'h0f, 2'h0);
      pads(4'h0, 4'h0, 4'ha, 4'h5);
      wr(`OFS_S_OUT_DATA, 8'h05, 2'h0);
      wr(`OFS_S_DIRECTION, 8'h0f, 2'h0);
      pads(4'ha, 4'h0, 4'ha, 4'h5);
      wr(`OFS_PULL_POLARITY, 8'h00, 2'h0);
      rd(`OFS_S_PIN_LEVEL, 8'h05, 2'h0);
      wr(`OFS_OPEN_DRAIN, 8'h00, 2'h0);
      pads(4'hf, 4'h5, 4'h0, 4'h0);
      wr(`OFS_M_PIN_DATA, 8'h20, 2'h0);
      wr(`OFS_M_DIRECTION, 8'h30, 2'h0);
      rd(`OFS_M_PIN_DATA, 8'h20, 2'h0);
      @(negedge aclk);
      `CHK("m out", 2'h2, m_pad_out)
      `CHK("m oe", 2'h3, m_pad_oe)
      @(posedge aclk);
      wr(`OFS_SPI_ENABLE, 8'h01, 2'h0);
      @(negedge aclk);
      `CHK("spi out", 2'h1, m_pad_out)
      `CHK("spi oe", 2'h1, m_pad_oe)
      `CHK("spi in", 2'h1, spi_in)
      {s_alt_en, s_alt_dir, s_alt_out} <= 12'h110;
      pads(4'hf, 4'h4, 4'h0, 4'h0);
      complete_run;
   end
endmodule
`default_nettype wire
